// ---- src/unba_uart.sv ----
/*
  nine-bit asynchronous transceiver with multiprocessor filtering and
  automatic address recognition. transmit bytes are queued in a FIFO.
  assumes serial_in_pin is already synchronous to clock, and that the
  baud timer overflow is a one-cycle pulse in this clock domain.
*/
// Operation
// R1: frame is start low, eight data bits lsb first, ninth bit, stop high.
// R2: transmitted ninth bit comes from tx_ninth_bit.
// R3: accepted frame loads ninth bit into rx_ninth_bit, byte into serial_buffer.
// R4: fixed-rate bit rate is clock/16 or clock/32.
// R5: variable-rate bit rate comes from baud timer overflow.
// R6: buffer write requests send; frame starts after next divide-by-16 rollover.
// R7: start bit, then shift output, first shift inserts one, later zeros.
// R8: after ninth bit, shift once more, stop sending, set tx_done_flag.
// R9: sample input at 16x; on falling edge reset counter, load all ones.
// R10: majority of samples at counter states 7, 8 and 9.
// R11: non-zero start bit abandons frame and resumes hunting.
// R12: nine-bit shift register; start bit at top triggers final shift and load.
// R13: load only if rx_done_flag clear and filter off or ninth bit one.
// R14: failed condition discards frame, buffer and flag unchanged.
// R15: one bit time after final shift, resume hunting for falling edge.
// R16: master sends addresses with ninth bit one, data with zero.
// R17: filter enable checks stop bit in ten-bit mode; none in shift mode.
// R18: with filter on, flag only ninth-bit-one bytes matching given or broadcast.
// R19: given address: station_address bits where mask is one must match.
// R20: broadcast: or of address and mask; zero bits are don't-care.
// R21: address and mask reset to zero, making filtering transparent.
// R22: software bit selects divide by 16 or 32 in fixed mode.
module unba_uart (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // serial pins
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    // rate control
    input wire logic variable_rate_mode,
    input wire logic fixed_div32,
    input wire logic baud_timer_ovf,
    // control bits
    input wire logic multiproc_filter_enable,
    input wire logic rx_enable,
    input wire logic tx_ninth_bit,
    // address registers
    input wire logic addr_write,
    input wire logic [7:0] addr_wdata,
    input wire logic mask_write,
    input wire logic [7:0] mask_wdata,
    output logic [7:0] station_address,
    output logic [7:0] station_address_mask,
    // transmit buffer write
    input wire logic tx_write,
    input wire logic [7:0] tx_wdata,
    output logic tx_write_ready,
    // receive buffer and flags
    output logic [7:0] serial_buffer,
    output logic rx_ninth_bit,
    output logic rx_done_flag,
    input wire logic rx_done_clear,
    output logic tx_done_flag,
    input wire logic tx_done_clear,
    output logic tx_busy
);
    import unba_pkg::*;

    // ----------------------------------------------------------------
    // rate tick and transmit divide-by-16 counter
    // ----------------------------------------------------------------
    logic tick16;
    logic [3:0] tx_cnt_reg;
    logic [3:0] rx_cnt_reg;

    unba_baud u_baud (
        .clock(clock),
        .reset_n(reset_n),
        .variable_rate_mode(variable_rate_mode),
        .fixed_div32(fixed_div32),
        .baud_timer_ovf(baud_timer_ovf),
        .tick16(tick16)
    );

    wire tx_rollover = tick16 && (tx_cnt_reg == UNBA_CNT_LAST);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tx_cnt_reg <= '0;
        end else if (tick16) begin
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // transmit queue
    // ----------------------------------------------------------------
    logic q_valid;
    logic q_ready;
    logic [8:0] q_data;

    // ninth bit is captured with the byte at write time
    // holds 32 queued words, plus one in the output register and one shifting
    unba_fifo #(.WIDTH(UNBA_SHIFT_W), .DEPTH(UNBA_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(tx_write),
        .in_ready(tx_write_ready),
        .in_data({tx_ninth_bit, tx_wdata}), // R2
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_data)
    );

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    unba_tx_t tx_state_reg;
    logic [8:0] tx_shift_reg;
    logic tx_out_reg;
    logic tx_done_reg;
    logic tx_first_reg;

    wire tx_take = (tx_state_reg == UNBA_TX_IDLE) && q_valid;
    assign q_ready = tx_take;
    // ninth bit at output with stop bit just left of it and zeros above
    // before the first shift the raw word could mimic that pattern
    wire tx_last = !tx_first_reg && (tx_shift_reg[8:1] == 8'h01); // R8
    wire tx_finish = (tx_state_reg == UNBA_TX_DATA) && tx_rollover && tx_last;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tx_state_reg <= UNBA_TX_IDLE;
            tx_shift_reg <= UNBA_TX_SHIFT_RESET;
            tx_out_reg <= 1'b1;
        end else begin
            unique case (tx_state_reg)
                UNBA_TX_IDLE: begin
                    tx_out_reg <= 1'b1;
                    if (q_valid) begin
                        tx_shift_reg <= q_data;
                        tx_state_reg <= UNBA_TX_WAIT; // R6
                    end
                end
                UNBA_TX_WAIT: begin
                    // start waits for the counter so bits align to it
                    if (tx_rollover) begin
                        tx_out_reg <= 1'b0; // R1 R6 R7
                        tx_state_reg <= UNBA_TX_START;
                    end
                end
                UNBA_TX_START: begin
                    if (tx_rollover) begin
                        tx_out_reg <= tx_shift_reg[0]; // R7
                        tx_state_reg <= UNBA_TX_DATA;
                    end
                end
                UNBA_TX_DATA: begin
                    if (tx_rollover) begin
                        if (tx_last) begin
                            // last shift leaves the stop bit at the output
                            tx_out_reg <= 1'b1; // R1 R8
                            tx_shift_reg <= UNBA_TX_SHIFT_RESET;
                            tx_state_reg <= UNBA_TX_IDLE;
                        end else begin
                            // first shift inserts the stop bit, later ones zero
                            tx_out_reg <= tx_shift_reg[1]; // R7
                            tx_shift_reg <= {1'b0, tx_shift_reg[8:1]} |
                                (tx_first_reg ? UNBA_STOP_TO_TOP : '0);
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // first-shift marker
    // ----------------------------------------------------------------
    // track whether the first shift has happened in this frame

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tx_first_reg <= 1'b0;
        end else if (tx_state_reg == UNBA_TX_START) begin
            tx_first_reg <= 1'b1;
        end else if ((tx_state_reg == UNBA_TX_DATA) && tx_rollover) begin
            tx_first_reg <= 1'b0;
        end
    end

    // hardware set wins over software clear
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tx_done_reg <= 1'b0;
        end else if (tx_finish) begin
            tx_done_reg <= 1'b1; // R8
        end else if (tx_done_clear) begin
            tx_done_reg <= 1'b0;
        end
    end

    assign serial_out_pin = tx_out_reg;
    assign tx_done_flag = tx_done_reg;
    assign tx_busy = (tx_state_reg != UNBA_TX_IDLE) || q_valid;

    // ----------------------------------------------------------------
    // address registers
    // ----------------------------------------------------------------
    logic [7:0] addr_reg;
    logic [7:0] mask_reg;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            addr_reg <= UNBA_ADDR_RESET; // R21
            mask_reg <= UNBA_MASK_RESET; // R21
        end else begin
            if (addr_write) begin
                addr_reg <= addr_wdata;
            end
            if (mask_write) begin
                mask_reg <= mask_wdata;
            end
        end
    end

    assign station_address = addr_reg;
    assign station_address_mask = mask_reg;

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    unba_rx_t rx_state_reg;
    logic [8:0] rx_shift_reg;
    logic rx_prev_reg;
    logic [2:0] rx_samp_reg;
    logic rx_first_reg;
    logic [7:0] rx_buf_reg;
    logic rx_b8_reg;
    logic rx_done_reg;

    // the edge detector starts high, so a line already low when reset ends counts as a falling edge
    wire rx_fall = rx_prev_reg && !serial_in_pin;
    wire rx_vote = (rx_samp_reg[0] & rx_samp_reg[1]) | (rx_samp_reg[0] & rx_samp_reg[2]) |
        (rx_samp_reg[1] & rx_samp_reg[2]); // R10
    wire rx_bit_end = tick16 && (rx_cnt_reg == UNBA_CNT_LAST);
    wire rx_sample = tick16 && ((rx_cnt_reg == UNBA_SAMPLE_A) ||
        (rx_cnt_reg == UNBA_SAMPLE_B) || (rx_cnt_reg == UNBA_SAMPLE_C));
    // start bit already at the top: the next shift pushes it out and is the final one
    wire rx_final = (rx_state_reg == UNBA_RX_BITS) && rx_bit_end && !rx_first_reg &&
        !rx_shift_reg[8]; // R12
    // final shift: data bits sit in rx_shift_reg[7:0] with bit 0 at the top,
    // since they entered lsb first from the bottom; the new bit is the ninth
    logic [7:0] rx_byte;
    for (genvar i = 0; i < UNBA_DATA_W; i++) begin : g_rx_rev
        assign rx_byte[i] = rx_shift_reg[7 - i]; // R1 R3
    end
    wire rx_b8 = rx_vote;
    wire given_hit = ((rx_byte ^ addr_reg) & mask_reg) == 8'h00; // R19
    wire [7:0] bcast = addr_reg | mask_reg; // R20
    wire bcast_hit = ((rx_byte ^ bcast) & bcast) == 8'h00; // R20
    // reset value leaves both compares all don't-care
    wire filt_ok = !multiproc_filter_enable ||
        (rx_b8 && (given_hit || bcast_hit)); // R13 R17 R18
    wire rx_accept = rx_final && !rx_done_reg && filt_ok; // R13 R14

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rx_state_reg <= UNBA_RX_HUNT;
            rx_shift_reg <= UNBA_RX_SHIFT_INIT;
            rx_prev_reg <= 1'b1;
            rx_samp_reg <= 3'h7;
            rx_first_reg <= 1'b0;
            rx_cnt_reg <= '0;
        end else begin
            if (tick16) begin
                rx_prev_reg <= serial_in_pin; // R9
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
            end
            if (rx_sample) begin
                rx_samp_reg <= {rx_samp_reg[1:0], serial_in_pin}; // R10
            end
            unique case (rx_state_reg)
                UNBA_RX_HUNT: begin
                    if (tick16 && rx_fall && rx_enable) begin
                        rx_cnt_reg <= 4'h1; // R9
                        rx_shift_reg <= UNBA_RX_SHIFT_INIT; // R9
                        rx_first_reg <= 1'b1;
                        rx_state_reg <= UNBA_RX_BITS;
                    end
                end
                UNBA_RX_BITS: begin
                    if (rx_bit_end) begin
                        rx_first_reg <= 1'b0;
                        if (rx_first_reg && rx_vote) begin
                            rx_state_reg <= UNBA_RX_HUNT; // R11
                        end else begin
                            // ones shift out at the top as bits enter at the bottom
                            rx_shift_reg <= {rx_shift_reg[7:0], rx_vote}; // R12
                            if (rx_final) begin
                                rx_state_reg <= UNBA_RX_HOLD;
                            end
                        end
                    end
                end
                UNBA_RX_HOLD: begin
                    // stop bit time passes before hunting again
                    if (rx_bit_end) begin
                        rx_shift_reg <= UNBA_RX_SHIFT_INIT;
                        rx_state_reg <= UNBA_RX_HUNT; // R15
                    end
                end
                default: rx_state_reg <= UNBA_RX_HUNT;
            endcase
        end
    end

    // rejected frames leave buffer, ninth bit and flag untouched
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rx_buf_reg <= 8'h00;
            rx_b8_reg <= 1'b0;
        end else if (rx_accept) begin
            rx_buf_reg <= rx_byte; // R3
            rx_b8_reg <= rx_b8; // R3
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rx_done_reg <= 1'b0;
        end else if (rx_accept) begin
            rx_done_reg <= 1'b1; // R13
        end else if (rx_done_clear) begin
            rx_done_reg <= 1'b0;
        end
    end

    assign serial_buffer = rx_buf_reg;
    assign rx_ninth_bit = rx_b8_reg;
    assign rx_done_flag = rx_done_reg;
endmodule

// ---- include/unba_pkg.sv ----
/*
  constants for the nine-bit serial transceiver with address recognition.
  assumes a single 25 MHz clock; no register bus, all control bits are ports.
*/
package unba_pkg;
    // ----------------------------------------------------------------
    // frame layout
    // ----------------------------------------------------------------
    localparam int UNBA_DATA_W = 8;
    localparam int UNBA_SHIFT_W = 9;
    localparam int UNBA_FIFO_DEPTH = 32;
    // ----------------------------------------------------------------
    // bit timing
    // ----------------------------------------------------------------
    localparam logic [3:0] UNBA_SAMPLE_A = 4'h7;
    localparam logic [3:0] UNBA_SAMPLE_B = 4'h8;
    localparam logic [3:0] UNBA_SAMPLE_C = 4'h9;
    localparam logic [3:0] UNBA_CNT_LAST = 4'hf;
    // fixed-rate mode: 16x tick every cycle (1/16) or every other cycle (1/32)
    localparam logic [0:0] UNBA_DIV32_INIT = 1'h0;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] UNBA_ADDR_RESET = 8'h00;
    localparam logic [7:0] UNBA_MASK_RESET = 8'h00;
    localparam logic [8:0] UNBA_RX_SHIFT_INIT = 9'h1ff;
    localparam logic [8:0] UNBA_TX_SHIFT_RESET = 9'h000;
    localparam logic [8:0] UNBA_STOP_TO_TOP = 9'h100;
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {UNBA_TX_IDLE, UNBA_TX_WAIT, UNBA_TX_START, UNBA_TX_DATA} unba_tx_t;
    typedef enum logic [1:0] {UNBA_RX_HUNT, UNBA_RX_BITS, UNBA_RX_HOLD} unba_rx_t;
endpackage

// ---- src/unba_fifo.sv ----
/*
  synchronous FIFO with valid/ready on both sides.
  assumes one clock and synchronous active-low reset.
*/
module unba_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic [WIDTH-1:0] out_reg;
    logic out_valid_reg;
    wire do_wr = in_valid && in_ready;
    // one output register; refilled whenever it is empty or drained
    wire do_rd = (cnt_reg != '0) && (!out_valid_reg || out_ready);
    assign in_ready = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid = out_valid_reg;
    assign out_data = out_reg;

    always_ff @(posedge clock) begin
        if (do_wr) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            out_reg <= '0;
            out_valid_reg <= 1'b0;
        end else begin
            if (do_wr) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_reg <= rd_reg + 1'b1;
                out_reg <= mem_reg[rd_reg];
                out_valid_reg <= 1'b1;
            end else if (out_ready) begin
                out_valid_reg <= 1'b0;
            end
            cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

// ---- src/unba_baud.sv ----
/*
  16x sampling tick generator for the nine-bit modes.
  assumes baud_timer_ovf is a one-cycle pulse from an external timer.
*/
module unba_baud (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // rate selection
    input wire logic variable_rate_mode,
    input wire logic fixed_div32,
    input wire logic baud_timer_ovf,
    // tick out
    output logic tick16
);
    import unba_pkg::*;
    logic half_reg;
    // fixed rate: tick at fclk (bit = fclk/16) or fclk/2 (bit = fclk/32)
    wire fixed_tick = fixed_div32 ? half_reg : 1'b1; // R4 R22
    assign tick16 = variable_rate_mode ? baud_timer_ovf : fixed_tick; // R5

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            half_reg <= UNBA_DIV32_INIT;
        end else begin
            half_reg <= ~half_reg;
        end
    end
endmodule

// ---- testbench/unba_uart_properties.sv ----
/*
  port assertions for the nine-bit transceiver.
  assumes the bind at the foot reaches every unba_uart instance.
*/
module unba_uart_checker (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // watched ports
    input wire logic serial_out_pin,
    input wire logic variable_rate_mode,
    input wire logic fixed_div32,
    input wire logic multiproc_filter_enable,
    input wire logic [7:0] station_address,
    input wire logic [7:0] station_address_mask,
    input wire logic [7:0] serial_buffer,
    input wire logic rx_ninth_bit,
    input wire logic rx_done_flag,
    input wire logic rx_done_clear,
    input wire logic tx_done_flag,
    input wire logic tx_write_ready,
    input wire logic tx_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    // low run of the line: inside a frame it is always whole bit times
    logic [9:0] low_run;
    wire [7:0] bcast = station_address | station_address_mask;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge clock) begin
        if (!reset_n || serial_out_pin) begin
            low_run <= 10'h000;
        end else begin
            low_run <= low_run + 10'h001;
        end
    end
    property p_reset_addr;
        $rose(reset_n) |-> station_address == 8'h00 && station_address_mask == 8'h00;
    endproperty
    a_reset_addr: assert property (p_reset_addr) else $error("address not cleared");
    property p_bit_len;
        $rose(serial_out_pin) && !variable_rate_mode |->
            (fixed_div32 ? low_run[4:0] == 5'h00 : low_run[3:0] == 4'h0);
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("bit time wrong");
    property p_start_len;
        $fell(serial_out_pin) |=> !serial_out_pin [*7];
    endproperty
    a_start_len: assert property (p_start_len) else $error("start bit short");
    property p_start_busy;
        $fell(serial_out_pin) |-> tx_busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("frame without request");
    property p_stop_after_done;
        $rose(tx_done_flag) |-> ##[0:2] serial_out_pin [*8];
    endproperty
    a_stop_after_done: assert property (p_stop_after_done) else $error("no stop bit");
    property p_idle_high;
        !tx_busy && !$past(tx_busy) |-> serial_out_pin;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle line low");
    property p_full_busy;
        !tx_write_ready |-> tx_busy;
    endproperty
    a_full_busy: assert property (p_full_busy) else $error("full while idle");
    property p_refused_hold;
        rx_done_flag && !rx_done_clear |=>
            rx_done_flag && $stable(serial_buffer) && $stable(rx_ninth_bit);
    endproperty
    a_refused_hold: assert property (p_refused_hold) else $error("buffer overwritten");
    property p_load_with_flag;
        $changed(serial_buffer) || $changed(rx_ninth_bit) |-> $rose(rx_done_flag);
    endproperty
    a_load_with_flag: assert property (p_load_with_flag) else $error("silent load");
    property p_filter_ninth;
        $rose(rx_done_flag) && multiproc_filter_enable |-> rx_ninth_bit;
    endproperty
    a_filter_ninth: assert property (p_filter_ninth) else $error("data byte passed");
    property p_filter_addr;
        $rose(rx_done_flag) && multiproc_filter_enable |->
            ((serial_buffer ^ station_address) & station_address_mask) == 8'h00 ||
            (serial_buffer & bcast) == bcast;
    endproperty
    a_filter_addr: assert property (p_filter_addr) else $error("address missed");
endmodule

bind unba_uart unba_uart_checker chk (.*);

// ---- testbench/unba_node.sv ----
/*
  far serial node: sends frames to the transceiver and decodes its output.
  assumes bit_clks clocks per bit; the line is driven at the falling edge.
*/
module unba_node (
    // clock and bit time
    input wire logic clock,
    input wire logic [7:0] bit_clks,
    // serial lines
    input wire logic from_dut,
    output logic to_dut
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] rx_q[$];
    initial to_dut = 1'h1;
    // bad cuts the start bit to three clocks, a glitch the voter must reject
    task automatic send(input logic [8:0] w, input bit bad);
        logic [10:0] f;
        f = {1'h1, w, 1'h0};
        for (int i = 0; i < 11; i++) begin
            to_dut = f[i];
            repeat (bad ? 3 : bit_clks) @(negedge clock);
            if (bad) break;
        end
        to_dut = 1'h1;
        repeat (bit_clks) @(negedge clock);
    endtask
    // sample mid-bit; word is stop, ninth, then data
    always begin
        logic [9:0] w;
        @(negedge clock);
        if (from_dut === 1'h0) begin
            repeat (bit_clks >> 1) @(negedge clock);
            for (int i = 0; i < 10; i++) begin
                repeat (bit_clks) @(negedge clock);
                w[i] = from_dut;
            end
            rx_q.push_back(w);
        end
    end
endmodule

// ---- testbench/unba_uart_test.sv ----
/*
  self-checking bench for the nine-bit transceiver.
  assumes the package, design, node model and checker are compiled first.
*/
module unba_uart_test;
    timeunit 1ns;
    timeprecision 1ns;
    import unba_pkg::*;
    logic clock, reset_n, serial_in_pin, serial_out_pin;
    logic variable_rate_mode, fixed_div32, baud_timer_ovf;
    logic multiproc_filter_enable, rx_enable, tx_ninth_bit;
    logic addr_write, mask_write, tx_write, tx_write_ready;
    logic [7:0] addr_wdata, mask_wdata, station_address, station_address_mask;
    logic [7:0] tx_wdata, serial_buffer, bit_clks, m_addr, m_mask;
    logic rx_ninth_bit, rx_done_flag, rx_done_clear;
    logic tx_done_flag, tx_done_clear, tx_busy, m_flag;
    logic [8:0] m_word = 9'h000;
    logic [1:0] ovf_cnt = 2'h0;
    int fails, n_checks;

    unba_uart uut (.*);
    unba_node node (.clock(clock), .bit_clks(bit_clks), .from_dut(serial_out_pin),
        .to_dut(serial_in_pin));

    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end
    // timer overflow every third clock: 48 clocks a bit in variable mode
    always @(negedge clock) begin
        ovf_cnt <= (ovf_cnt == 2'h2) ? 2'h0 : ovf_cnt + 2'h1;
        baud_timer_ovf <= (ovf_cnt == 2'h2);
    end
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_q(input int n, input int lim);
        int i;
        for (i = 0; i < lim && node.rx_q.size() < n; i++) @(negedge clock);
        if (i == lim) begin
            fails++;
            $display("CHECK FAILED frames exp %0d seen %0d", n, node.rx_q.size());
            finish_test();
        end
    endtask
    // back-to-back writes; words refused while the queue is full are not expected
    task automatic tx_burst(input int n);
        logic [8:0] w, exp_q[$];
        node.rx_q.delete();
        for (int i = 0; i < n; i++) begin
            w = 9'($urandom);
            tx_wdata = w[7:0];
            tx_ninth_bit = w[8];
            tx_write = 1'h1;
            if (tx_write_ready) exp_q.push_back(w);
            @(negedge clock);
        end
        tx_write = 1'h0;
        check("refused", 10'(exp_q.size() < n), 10'(n > 33));
        wait_q(exp_q.size(), exp_q.size() * 13 * bit_clks + 100);
        while (exp_q.size() > 0)
            check("tx frame", node.rx_q.pop_front(), {1'h1, exp_q.pop_front()});
        check("tx_done_flag", 10'(tx_done_flag), 10'h1);
        tx_done_clear = 1'h1;
        @(negedge clock);
        tx_done_clear = 1'h0;
        repeat (bit_clks) @(negedge clock);
        check("tx_done_clear", 10'(tx_done_flag), 10'h0);
        check("tx_busy", 10'(tx_busy), 10'h0);
    endtask
    task automatic rx_frame(input logic [8:0] w, input bit bad, input bit clr);
        logic [7:0] bc;
        logic hit;
        bc = m_addr | m_mask;
        hit = (((w[7:0] ^ m_addr) & m_mask) == 8'h00) || ((w[7:0] & bc) == bc);
        if (!bad && !m_flag && (!multiproc_filter_enable || (w[8] && hit))) begin
            m_flag = 1'h1;
            m_word = w;
        end
        node.send(w, bad);
        check("rx_done_flag", 10'(rx_done_flag), 10'(m_flag));
        check("rx word", {1'h0, rx_ninth_bit, serial_buffer}, {1'h0, m_word});
        rx_done_clear = clr;
        @(negedge clock);
        rx_done_clear = 1'h0;
        if (clr) m_flag = 1'h0;
    endtask
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        logic [7:0] tbl [4];
        tbl = '{8'hc2, 8'h01, 8'hff, 8'hc1};
        {reset_n, variable_rate_mode, fixed_div32} = 3'h0;
        {multiproc_filter_enable, tx_ninth_bit, addr_write, mask_write} = 4'h0;
        {tx_write, rx_done_clear, tx_done_clear, m_flag, rx_enable} = 5'h01;
        {addr_wdata, mask_wdata, tx_wdata, m_addr, m_mask} = 40'h0;
        void'($urandom(9));
        repeat (2) @(negedge clock);
        reset_n = 1'h1;
        @(negedge clock);
        check("station_address", 10'(station_address), 10'(UNBA_ADDR_RESET));
        check("address mask", 10'(station_address_mask), 10'(UNBA_MASK_RESET));
        check("serial_out_pin", 10'(serial_out_pin), 10'h1);
        for (int r = 0; r < 3; r++) begin
            variable_rate_mode = (r == 2);
            fixed_div32 = (r == 1);
            bit_clks = (r == 0) ? 8'h10 : (r == 1) ? 8'h20 : 8'h30;
            tx_burst(r == 0 ? 40 : 3);
            rx_frame(9'($urandom), 1'h0, 1'h1);
            $display("test rate %0d done", r);
        end
        {variable_rate_mode, fixed_div32} = 2'h0;
        bit_clks = 8'h10;
        rx_frame(9'h0a5, 1'h0, 1'h0);
        rx_frame(9'h15a, 1'h0, 1'h1);
        rx_frame(9'h000, 1'h1, 1'h1);
        rx_frame(9'h13c, 1'h0, 1'h1);
        $display("test refusal done");
        multiproc_filter_enable = 1'h1;
        rx_frame(9'h033, 1'h0, 1'h1);
        rx_frame(9'h133, 1'h0, 1'h1);
        addr_wdata = 8'hc0;
        mask_wdata = 8'hfd;
        {addr_write, mask_write} = 2'h3;
        @(negedge clock);
        {addr_write, mask_write} = 2'h0;
        {m_addr, m_mask} = 16'hc0fd;
        check("address readback", {station_address, 2'h0}, {8'hc0, 2'h0});
        check("mask readback", {station_address_mask, 2'h0}, {8'hfd, 2'h0});
        foreach (tbl[i]) rx_frame({1'h1, tbl[i]}, 1'h0, 1'h1);
        $display("test address done");
        finish_test();
    end
endmodule
